// ===== design/piw_top.sv
`timescale 1ns/1ps
// Behaviour
// - Purge bit set: every window transaction carries invalidating transfer type
// - Coherence bit set: every window transaction asserts global snoop
// - Read-ahead prefetch only while the window allows prefetch
// - Writes posted only while the window allows posting
// - Window answers writes only when its write allow bit is set
// - Window answers reads only when its read allow bit is set
// - First read-multiple prefetch is always four cache lines
// - Later prefetches start when FIFO drains to the refill level
// - Refill level ignored for windows without read-ahead
// - Processor address upper half is PCI upper half plus shift
// - Pointer register reachable from processor bus only
// - Big-endian mode shows pointer register byte-swapped
// - Register and function numbers copied onto address lines
// - Segment zero gives Type 0 cycle, nonzero Type 1
// - Translate bit clear passes data port accesses as I/O cycles
module piw_top (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Processor-bus register port
  input  wire logic                  reg_sel,
  input  wire logic                  reg_wr,
  input  wire logic [11:0]           reg_addr,
  input  wire logic [3:0]            reg_be,
  input  wire logic [31:0]           reg_wdata,
  output logic                       reg_ack,
  output logic      [31:0]           reg_rdata,
  // Endian mode pin
  input  wire logic                  big_endian,
  // Inbound PCI slave window path
  input  wire piw_pkg::piw_in_req_t  in_req,
  output piw_pkg::piw_in_rsp_t       in_rsp,
  // Prefetch control
  input  wire logic [2:0]            fifo_lines,
  input  wire logic                  pf_done,
  input  wire logic                  rm_end,
  output logic                       pf_req,
  output logic      [2:0]            pf_lines,
  // Configuration data port access
  input  wire logic                  cfg_acc,
  output piw_pkg::piw_cfg_t          cfg_out
);
  import piw_pkg::*;

  function automatic logic [31:0] swap32(input logic [31:0] v);
    swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction : swap32

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  // ****************************************************************
  // Endian pin synchroniser
  // ****************************************************************
  logic be_meta_q;
  logic be_mode_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      be_meta_q <= 1'b0;
      be_mode_q <= 1'b0;
    end else begin
      be_meta_q <= big_endian;
      be_mode_q <= be_meta_q;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0]  attr_q [NUM_WIN];
  logic [15:0] shft_q [NUM_WIN];
  logic [31:0] ptr_q;
  logic [31:0] ptr_wd;
  logic [31:0] ptr_wm;
  logic        ptr_hit;

  // Only the processor port reaches the pointer; PCI has no path.
  assign ptr_hit = reg_sel && (reg_addr == PTR_OFF);
  assign ptr_wd  = be_mode_q ? swap32(reg_wdata) : reg_wdata;
  assign ptr_wm  = (be_mode_q ? swap32(be_mask(reg_be)) : be_mask(reg_be))
                   & PTR_MASK;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= PTR_RST;
    end else if (ptr_hit && reg_wr) begin
      ptr_q <= (ptr_q & ~ptr_wm) | (ptr_wd & ptr_wm);
    end
  end

  // One attribute and one shift register per window.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_WIN; i++) begin
        attr_q[i] <= ATTR_RST;
        shft_q[i] <= SHFT_RST;
      end
    end else if (reg_sel && reg_wr) begin
      for (int i = 0; i < NUM_WIN; i++) begin
        if (reg_addr == ATTR_OFF + WIN_STEP * 12'(i) && reg_be[0]) begin
          attr_q[i] <= reg_wdata[7:0];
        end
        if (reg_addr == SHFT_OFF + WIN_STEP * 12'(i)) begin
          if (reg_be[0]) shft_q[i][7:0]  <= reg_wdata[7:0];
          if (reg_be[1]) shft_q[i][15:8] <= reg_wdata[15:8];
        end
      end
    end
  end

  // Unmapped offsets read zero but are still acknowledged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_ack   <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_ack   <= reg_sel;
      reg_rdata <= 32'h0000_0000;
      if (ptr_hit) begin
        reg_rdata <= be_mode_q ? swap32(ptr_q) : ptr_q;
      end
      for (int i = 0; i < NUM_WIN; i++) begin
        if (reg_sel && reg_addr == ATTR_OFF + WIN_STEP * 12'(i)) begin
          reg_rdata <= {24'h00_0000, attr_q[i]};
        end
        if (reg_sel && reg_addr == SHFT_OFF + WIN_STEP * 12'(i)) begin
          reg_rdata <= {16'h0000, shft_q[i]};
        end
      end
    end
  end

  // ****************************************************************
  // Inbound window path
  // ****************************************************************
  logic [7:0]  win_attr;
  logic [15:0] win_shft;
  logic        win_ok;

  // Only the decoded window's pair is consulted.
  assign win_attr = attr_q[in_req.win];
  assign win_shft = shft_q[in_req.win];
  assign win_ok   = in_req.write ? win_attr[ATTR_WRA]
                                 : win_attr[ATTR_RDA];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_rsp <= '0;
    end else begin
      in_rsp.taken        <= in_req.valid && win_ok;
      in_rsp.decline      <= in_req.valid && !win_ok;
      in_rsp.posted       <= in_req.valid && win_ok && in_req.write
                             && win_attr[ATTR_PWA];
      in_rsp.purge        <= in_req.valid && win_ok
                             && win_attr[ATTR_PURGE];
      in_rsp.snoop_global <= in_req.valid && win_ok
                             && win_attr[ATTR_COHER];
      in_rsp.cpu_addr     <= {16'(in_req.addr[31:16] + win_shft),
                              in_req.addr[15:0]};
    end
  end

  // ****************************************************************
  // Read-multiple prefetch engine
  // ****************************************************************
  piw_pf_state_t pf_q;
  logic [1:0]    lvl_q;
  logic          rm_start;

  // Prefetch disabled windows never start the engine.
  assign rm_start = in_req.valid && win_ok && !in_req.write
                    && in_req.multiple && win_attr[ATTR_PFA];

  // Level is latched only for read-ahead windows.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 2'b00;
    end else if (rm_start && pf_q == PIW_PF_IDLE) begin
      lvl_q <= win_attr[ATTR_LVL +: 2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pf_q     <= PIW_PF_IDLE;
      pf_req   <= 1'b0;
      pf_lines <= 3'h0;
    end else begin
      pf_req <= 1'b0;
      unique case (pf_q)
        PIW_PF_IDLE: begin
          if (rm_start) begin
            pf_q     <= PIW_PF_WAIT;
            pf_req   <= 1'b1;
            pf_lines <= PF_FIRST_LINES;
          end
        end
        PIW_PF_ISSUE: begin
          pf_q     <= PIW_PF_WAIT;
          pf_req   <= 1'b1;
          pf_lines <= PF_NEXT_LINES;
        end
        PIW_PF_WAIT: begin
          if (rm_end) pf_q <= PIW_PF_IDLE;
          else if (pf_done) pf_q <= PIW_PF_WATCH;
        end
        PIW_PF_WATCH: begin
          if (rm_end) pf_q <= PIW_PF_IDLE;
          else if (fifo_lines <= {1'b0, lvl_q}) begin
            pf_q <= PIW_PF_ISSUE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Configuration cycle translation
  // ****************************************************************
  // Type 0 leaves slot select to the outer decode; only low fields here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_out <= '0;
    end else begin
      cfg_out.valid <= cfg_acc;
      if (!ptr_q[PTR_EN]) begin
        cfg_out.kind <= PIW_CFG_IO;
        cfg_out.ad   <= 32'h0000_0000;
      end else if (ptr_q[PTR_BUS_LO +: 8] == 8'h00) begin
        cfg_out.kind <= PIW_CFG_TYPE0;
        cfg_out.ad   <= {21'h00_0000, ptr_q[10:2], 2'b00};
      end else begin
        cfg_out.kind <= PIW_CFG_TYPE1;
        cfg_out.ad   <= {8'h00, ptr_q[23:2], 2'b01};
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_write_gate: assert property (
    in_req.valid && in_req.write && !attr_q[in_req.win][ATTR_WRA]
    |=> in_rsp.decline && !in_rsp.taken)
    else $error("write taken by closed window");
  chk_read_gate: assert property (
    in_req.valid && !in_req.write && attr_q[in_req.win][ATTR_RDA]
    |=> in_rsp.taken && !in_rsp.decline)
    else $error("read refused by open window");
  chk_purge_type: assert property (
    in_rsp.taken |-> in_rsp.purge == $past(attr_q[in_req.win][ATTR_PURGE]))
    else $error("purge code mismatch");
  chk_global_snoop: assert property (
    in_rsp.taken |-> in_rsp.snoop_global
                     == $past(attr_q[in_req.win][ATTR_COHER]))
    else $error("global snoop mismatch");
  chk_post_allow: assert property (
    in_rsp.posted |-> $past(attr_q[in_req.win][ATTR_PWA] && in_req.write))
    else $error("posting without allow");
  chk_prefetch_allow: assert property (
    $rose(pf_req) && $past(pf_q) == PIW_PF_IDLE
    |-> $past(attr_q[in_req.win][ATTR_PFA]))
    else $error("prefetch without allow");
  chk_first_four: assert property (
    pf_q == PIW_PF_IDLE && rm_start |=> pf_req && pf_lines == 3'h4)
    else $error("first prefetch not four lines");
  chk_refill_level: assert property (
    pf_q == PIW_PF_WATCH && !rm_end && fifo_lines <= {1'b0, lvl_q}
    |=> ##1 pf_req && pf_lines == PF_NEXT_LINES)
    else $error("refill prefetch missing");
  chk_addr_sum: assert property (
    in_req.valid |=> in_rsp.cpu_addr[31:16]
      == 16'($past(in_req.addr[31:16]) + $past(shft_q[in_req.win])))
    else $error("address offset wrong");
  chk_cfg_kind: assert property (
    cfg_acc && ptr_q[PTR_EN] && ptr_q[23:16] != 8'h00
    |=> cfg_out.valid && cfg_out.kind == PIW_CFG_TYPE1)
    else $error("type 1 not generated");
  chk_io_pass: assert property (
    cfg_acc && !ptr_q[PTR_EN] |=> cfg_out.valid && cfg_out.kind == PIW_CFG_IO)
    else $error("io pass-through missing");
  chk_cfg_fields: assert property (
    cfg_acc && ptr_q[PTR_EN] |=> cfg_out.ad[10:2] == $past(ptr_q[10:2]))
    else $error("register or function number lost");

endmodule : piw_top

// ===== include/piw_pkg.sv
package piw_pkg;

  // ****************************************************************
  // Window count and register map
  // ****************************************************************
  localparam int unsigned NUM_WIN  = 4;
  localparam int unsigned WIN_W    = 2;
  localparam logic [11:0] PTR_OFF  = 12'hcf8;
  localparam logic [11:0] ATTR_OFF = 12'h100;
  localparam logic [11:0] SHFT_OFF = 12'h104;
  localparam logic [11:0] WIN_STEP = 12'h008;

  // ****************************************************************
  // Attribute fields and reset values
  // ****************************************************************
  localparam int unsigned ATTR_PURGE = 7;
  localparam int unsigned ATTR_COHER = 6;
  localparam int unsigned ATTR_PFA   = 5;
  localparam int unsigned ATTR_PWA   = 4;
  localparam int unsigned ATTR_WRA   = 3;
  localparam int unsigned ATTR_RDA   = 2;
  localparam int unsigned ATTR_LVL   = 0;
  localparam logic [7:0]  ATTR_RST   = 8'h00;
  localparam logic [15:0] SHFT_RST   = 16'h0000;

  // ****************************************************************
  // Pointer fields (little-endian view)
  // ****************************************************************
  localparam int unsigned PTR_REG_LO = 2;
  localparam int unsigned PTR_SUB_LO  = 8;
  localparam int unsigned PTR_SLOT_LO = 11;
  localparam int unsigned PTR_BUS_LO = 16;
  localparam int unsigned PTR_EN     = 31;
  localparam logic [31:0] PTR_MASK   = 32'h80ff_fffc;
  localparam logic [31:0] PTR_RST    = 32'h0000_0000;

  // ****************************************************************
  // Prefetch sizes in cache lines
  // ****************************************************************
  localparam logic [2:0] PF_FIRST_LINES = 3'h4;
  localparam logic [2:0] PF_NEXT_LINES  = 3'h1;

  typedef enum logic [1:0] {
    PIW_PF_IDLE  = 2'b00,
    PIW_PF_WAIT  = 2'b01,
    PIW_PF_WATCH = 2'b11,
    PIW_PF_ISSUE = 2'b10
  } piw_pf_state_t;

  typedef enum logic [1:0] {
    PIW_CFG_IO    = 2'b00,
    PIW_CFG_TYPE0 = 2'b01,
    PIW_CFG_TYPE1 = 2'b10
  } piw_cfg_kind_t;

  typedef struct packed {
    logic             valid;
    logic [WIN_W-1:0] win;
    logic             write;
    logic             multiple;
    logic [31:0]      addr;
  } piw_in_req_t;

  typedef struct packed {
    logic        taken;
    logic        decline;
    logic        posted;
    logic        purge;
    logic        snoop_global;
    logic [31:0] cpu_addr;
  } piw_in_rsp_t;

  typedef struct packed {
    logic          valid;
    piw_cfg_kind_t kind;
    logic [31:0]   ad;
  } piw_cfg_t;

endpackage : piw_pkg

// ===== dv/piw_far_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Processor-bus memory answering prefetch reads into the FIFO
// ****************************************************************
module piw_far_model #(
  parameter int LAT = 3
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Prefetch traffic
  input  wire logic       pf_req,
  input  wire logic [2:0] pf_lines,
  output logic            pf_done,
  // FIFO level, drained by the PCI side
  input  wire logic       drain,
  output logic      [2:0] fifo_lines
);
  logic       busy_q;
  logic [3:0] cnt_q;
  logic [2:0] add_q;
  logic       fill;

  // Slow memory: data lands only after the full latency
  assign fill = busy_q && cnt_q == 4'h1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q  <= 1'b0;
      cnt_q   <= 4'h0;
      add_q   <= 3'h0;
      pf_done <= 1'b0;
    end else begin
      pf_done <= fill;
      if (pf_req) begin
        busy_q <= 1'b1;
        cnt_q  <= 4'(LAT);
        add_q  <= pf_lines;
      end else if (fill) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_lines <= 3'h0;
    end else if (fill) begin
      fifo_lines <= fifo_lines + add_q;
    end else if (drain && fifo_lines != 3'h0) begin
      fifo_lines <= fifo_lines - 3'h1;
    end
  end
endmodule : piw_far_model

// ===== dv/piw_top_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module piw_top_test;
  import piw_pkg::*;
  logic clk = 0, rst_n = 0, reg_sel = 0, reg_wr = 0, big_endian = 0;
  logic [11:0] reg_addr = 12'h000;
  logic [3:0] reg_be = 4'hf;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
  logic reg_ack, pf_req, pf_done, rm_end = 0, cfg_acc = 0, drain = 0;
  logic [2:0] fifo_lines, pf_lines;
  piw_in_req_t in_req = '0;
  piw_in_rsp_t in_rsp, rsp;
  piw_cfg_t cfg_out;
  int fails = 0, checks = 0;
  logic [7:0] attr [4] = '{8'hcc, 8'h18, 8'h07, 8'h26};
  logic [15:0] sh [4] = '{16'h1000, 16'h2100, 16'h3210, 16'hf000};

  always #50 clk = ~clk;

  piw_top dut (.clk(clk), .rst_n(rst_n), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
    .big_endian(big_endian), .in_req(in_req), .in_rsp(in_rsp),
    .fifo_lines(fifo_lines), .pf_done(pf_done), .rm_end(rm_end),
    .pf_req(pf_req), .pf_lines(pf_lines), .cfg_acc(cfg_acc),
    .cfg_out(cfg_out));
  piw_far_model far (.clk(clk), .rst_n(rst_n), .pf_req(pf_req),
    .pf_lines(pf_lines), .pf_done(pf_done), .drain(drain),
    .fifo_lines(fifo_lines));

  task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_sel <= 1'b1; reg_wr <= w; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_sel <= 1'b0;
    #1 `CHK("ack", 1'b1, reg_ack)
    rd = reg_rdata;
  endtask : rw

  task automatic inb(input logic [1:0] w, input logic wr, mu,
                     input logic [31:0] a);
    @(posedge clk);
    in_req <= '{1'b1, w, wr, mu, a};
    @(posedge clk);
    in_req.valid <= 1'b0;
    #1 rsp = in_rsp;
  endtask : inb

  task automatic cfg(input logic [31:0] p, input piw_cfg_kind_t k,
                     input logic [31:0] ad);
    rw(1'b1, PTR_OFF, p);
    @(posedge clk) cfg_acc <= 1'b1;
    @(posedge clk) cfg_acc <= 1'b0;
    #1 `CHK("cfg valid", 1'b1, cfg_out.valid)
    `CHK("cfg kind", k, cfg_out.kind)
    `CHK("cfg ad", ad, cfg_out.ad)
  endtask : cfg

  task automatic test_windows;
    logic al;
    logic [31:0] a;
    for (int i = 0; i < 4; i++) begin
      rw(1'b0, 12'(ATTR_OFF + WIN_STEP * i), 32'h0);
      `CHK("attr rst", 32'h0, rd)
      rw(1'b1, 12'(ATTR_OFF + WIN_STEP * i), {24'h0, attr[i]});
      rw(1'b1, 12'(SHFT_OFF + WIN_STEP * i), {16'h0, sh[i]});
    end
    for (int i = 0; i < 4; i++)
      for (int w = 0; w < 2; w++) begin
        a = 32'h9876_5432 + 32'(i);
        inb(2'(i), w[0], 1'b0, a);
        al = w[0] ? attr[i][ATTR_WRA] : attr[i][ATTR_RDA];
        `CHK("taken", al, rsp.taken)
        `CHK("decline", !al, rsp.decline)
        `CHK("posted", al & w[0] & attr[i][ATTR_PWA], rsp.posted)
        `CHK("purge", al & attr[i][ATTR_PURGE], rsp.purge)
        `CHK("snoop", al & attr[i][ATTR_COHER], rsp.snoop_global)
        a = {a[31:16] + sh[i], a[15:0]};
        `CHK("addr", a, rsp.cpu_addr)
      end
  endtask : test_windows

  task automatic test_prefetch;
    logic early, seen;
    int gap;
    inb(2'd3, 1'b0, 1'b1, 32'h0000_0040);
    `CHK("pf first", 1'b1, pf_req)
    `CHK("pf lines", 3'h4, pf_lines)
    for (int n = 0; n < 20 && !pf_done; n++) @(posedge clk) #1;
    early = 1'b0;
    seen = 1'b0;
    gap = -1;
    @(posedge clk) drain <= 1'b1;
    // Refill must follow the level crossing by exactly two edges
    for (int n = 0; n < 12 && !seen; n++) begin
      @(posedge clk) #1 seen = pf_req;
      if (gap >= 0) gap++;
      if (seen) early = (gap < 0);
      else if (gap < 0 && fifo_lines <= {1'b0, attr[3][1:0]}) gap = 0;
    end
    @(posedge clk) drain <= 1'b0;
    `CHK("pf early", 1'b0, early)
    `CHK("pf refill", 1'b1, seen)
    `CHK("pf refill gap", 2, gap)
    `CHK("pf refill lines", 3'h1, pf_lines)
    @(posedge clk) rm_end <= 1'b1;
    @(posedge clk) rm_end <= 1'b0;
    inb(2'd2, 1'b0, 1'b1, 32'h0000_0080);
    seen = pf_req;
    repeat (8) @(posedge clk) #1 seen |= pf_req;
    `CHK("pf off", 1'b0, seen)
  endtask : test_prefetch

  task automatic test_pointer;
    logic [31:0] p;
    rw(1'b0, PTR_OFF, 32'h0);
    `CHK("ptr rst", 32'h0, rd)
    rw(1'b1, PTR_OFF, 32'hffff_ffff);
    rw(1'b0, PTR_OFF, 32'h0);
    `CHK("ptr mask", 32'h80ff_fffc, rd)
    rw(1'b0, 12'h200, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    cfg(32'h8000_2b28, PIW_CFG_TYPE0,
        {21'h0, 3'h3, 6'h0a, 2'b00});
    cfg(32'h8012_2b28, PIW_CFG_TYPE1,
        {8'h0, 8'h12, 5'h05, 3'h3, 6'h0a, 2'b01});
    p = 32'h0012_2b28;
    cfg(p, PIW_CFG_IO, 32'h0);
    @(posedge clk) big_endian <= 1'b1;
    repeat (3) @(posedge clk);
    rw(1'b0, PTR_OFF, 32'h0);
    `CHK("ptr swap", {p[7:0], p[15:8], p[23:16], p[31:24]}, rd)
    // Lane 3 in big-endian view lands on the register-number byte
    @(posedge clk) reg_be <= 4'h8;
    rw(1'b1, PTR_OFF, 32'h3c00_0000);
    @(posedge clk) reg_be <= 4'hf;
    rw(1'b0, PTR_OFF, 32'h0);
    `CHK("ptr lane", {8'h3c, p[15:8], p[23:16], p[31:24]}, rd)
    @(posedge clk) big_endian <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : test_pointer

  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    test_pointer();
    test_windows();
    test_prefetch();
    give_verdict();
  end
endmodule : piw_top_test
